// *** hw/ir_event_defines.svh ***
// Offsets, field positions, reset values and widths of the infrared port event block
`ifndef IR_EVENT_DEFINES_SVH
`define IR_EVENT_DEFINES_SVH

// Register byte addresses
`define OFS_FRAME_INFO      32'h808b_0020
`define OFS_SLOW_IR_TEST    32'h808b_0030
`define OFS_MR_STATUS       32'h808b_0080
`define OFS_MR_INT_MASK     32'h808b_0084
`define OFS_MR_INT_PENDING  32'h808b_0088
`define OFS_FR_STATUS       32'h808b_0180
`define OFS_FR_INT_MASK     32'h808b_0184
`define OFS_FR_INT_PENDING  32'h808b_0188

// Event positions shared by status, mask and pending registers
`define EVENT_W             7
`define BIT_RX_FRAME_LOST   6
`define BIT_RX_INFO_LOST    5
`define BIT_RX_FRAME_DONE   4
`define BIT_RX_SERVICE      3
`define BIT_TX_ABORTED      2
`define BIT_TX_FRAME_DONE   1
`define BIT_TX_SERVICE      0

// Sticky write-one-to-clear bits and live read-only bits
`define STICKY_BITS         7'h76
`define LIVE_BITS           7'h09

// Reset values
`define STATUS_RST          7'h00
`define MASK_RST            7'h00
`define READ_ZERO           32'h0000_0000

// Frame information layout: four flags low, byte count above
`define INFO_FLAGS_W        4
`define INFO_COUNT_W        11
`define INFO_COUNT_LSB      4
`define INFO_RST            15'h0000

// Slow infrared test register: four live bits from bit 4 up
`define TEST_W              4
`define TEST_LSB            4

`endif

// *** hw/ir_event_pkg.sv ***
// Types shared by the infrared port event block
`include "ir_event_defines.svh"

package ir_event_pkg;

  // One bit per event position
  typedef logic [`EVENT_W-1:0] event_vec_t;

  // Register selected by an APB address
  typedef enum {
    sel_none,
    sel_frame_info,
    sel_slow_test,
    sel_mr_status,
    sel_mr_mask,
    sel_mr_pending,
    sel_fr_status,
    sel_fr_mask,
    sel_fr_pending
  } reg_sel_t;

endpackage : ir_event_pkg

// *** hw/ir_sync_bits.sv ***
// Two flip-flop synchroniser for the slow infrared observation signals
`include "ir_event_defines.svh"

module ir_sync_bits
  import ir_event_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [`TEST_W-1:0]   i_async,
  output logic      [`TEST_W-1:0]   o_sync
);

  genvar g;

  // One independent two-stage chain per bit; the first stage feeds only the second
  generate
    for (g = 0; g < `TEST_W; g = g + 1) begin : g_chain
      logic meta;    // First stage, may be metastable
      logic stable;  // Second stage, safe to read

      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          meta   <= 1'b0;
          stable <= 1'b0; // RULE16
        end else begin
          meta   <= i_async[g];
          stable <= meta;
        end
      end

      assign o_sync[g] = stable;
    end
  endgenerate

endmodule : ir_sync_bits

// *** hw/ir_event_bank.sv ***
// Status, mask and pending logic for one infrared rate path
`include "ir_event_defines.svh"

module ir_event_bank
  import ir_event_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire event_vec_t i_set,
  input  wire event_vec_t i_live,
  input  wire logic       i_status_wr,
  input  wire logic       i_mask_wr,
  input  wire event_vec_t i_wdata,
  input  wire logic       i_info_read,
  output event_vec_t      o_status,
  output event_vec_t      o_mask,
  output event_vec_t      o_pending,
  output logic            o_irq
);

  event_vec_t sticky;      // Stored event flags
  event_vec_t clr;         // Bits cleared this cycle
  event_vec_t mask;        // Interrupt enables

  // Write-one clears sticky bits only; zeros and live bits are untouched
  always_comb begin
    clr = i_status_wr ? (i_wdata & `STICKY_BITS) : `STATUS_RST; // RULE18
    if (i_info_read) begin
      clr[`BIT_RX_FRAME_DONE] = 1'b1; // RULE5
    end
  end

  // Set is applied after clear so a same-cycle event survives
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sticky <= `STATUS_RST;
    end else begin
      sticky <= ((sticky & ~clr) | i_set) & `STICKY_BITS; // RULE19
    end
  end

  // Mask register, plain read/write
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mask <= `MASK_RST;
    end else if (i_mask_wr) begin
      mask <= i_wdata; // RULE11
    end
  end

  assign o_status  = sticky | (i_live & `LIVE_BITS);
  assign o_mask    = mask;
  assign o_pending = o_status & mask; // RULE12
  assign o_irq     = |o_pending;

endmodule : ir_event_bank

// *** hw/ir_port_events.sv ***
// Event status, masking and interrupt block of the infrared communication port
//
// What this block does
// RULE1: Frame lost set on overrun at frame start
// RULE2: Lost when newest FIFO entry holds old end
// RULE3: Info lost set when frame done still set
// RULE4: Last word read sets done, captures frame info
// RULE5: Reading frame info clears frame done
// RULE6: Receive service live: data, enabled, not discarding
// RULE7: Receive service drops once buffer empties
// RULE8: Transmit aborted set only with underrun abort
// RULE9: Transmit complete set on any frame end
// RULE10: Transmit service live: not full and enabled
// RULE11: Mask bit gates its status bit
// RULE12: Pending bit is status AND mask
// RULE13: Port interrupt follows any medium-rate pending bit
// RULE14: Fast path has own registers and interrupt
// RULE15: Test register shows four live serial signals
// RULE16: Test register resets to zero
// RULE17: Frame info keeps flags, eleven-bit count
// RULE18: Zero writes and read-only bits leave state
// RULE19: Set event beats same-cycle clear
`include "ir_event_defines.svh"

module ir_port_events
  import ir_event_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Rate selection from the port control word
  input  wire logic        i_fast_rate_sel,
  // Receive datapath events
  input  wire logic        i_rx_overrun,
  input  wire logic        i_rx_tail_has_eof,
  input  wire logic        i_rx_last_word_read,
  input  wire logic        i_rx_fifo_empty,
  input  wire logic        i_rx_discarding,
  input  wire logic        i_rx_enable,
  // Receive flag word and byte count of the frame being closed
  input  wire logic        i_rx_framing_err,
  input  wire logic        i_rx_overrun_flag,
  input  wire logic        i_rx_crc_err,
  input  wire logic        i_rx_abort,
  input  wire logic [15:0] i_rx_byte_count,
  // Transmit datapath events
  input  wire logic        i_tx_frame_sent,
  input  wire logic        i_tx_frame_aborted,
  input  wire logic        i_tx_underrun_abort_ctl,
  input  wire logic        i_tx_fifo_full,
  input  wire logic        i_tx_enable,
  // Slow infrared signals observed by the test register
  input  wire logic        i_slow_ir_enable,
  input  wire logic        i_slow_ir_serial_out,
  input  wire logic        i_uart_tx_serial_in,
  input  wire logic        i_uart_rx_serial_out,
  // Interrupts
  output logic             o_port_irq,
  output logic             o_fast_irq
);

  // Address decode, used by the read path, the write path and the error answer
  function automatic reg_sel_t decode_addr(input logic [31:0] addr);
    reg_sel_t sel;
    sel = sel_none;
    case (addr)
      `OFS_FRAME_INFO:     sel = sel_frame_info;
      `OFS_SLOW_IR_TEST:   sel = sel_slow_test;
      `OFS_MR_STATUS:      sel = sel_mr_status;
      `OFS_MR_INT_MASK:    sel = sel_mr_mask;
      `OFS_MR_INT_PENDING: sel = sel_mr_pending;
      `OFS_FR_STATUS:      sel = sel_fr_status;
      `OFS_FR_INT_MASK:    sel = sel_fr_mask;
      `OFS_FR_INT_PENDING: sel = sel_fr_pending;
      default:             sel = sel_none;
    endcase
    return sel;
  endfunction : decode_addr

  // Bus phase qualifiers
  reg_sel_t   bus_sel;           // Register addressed by the current transfer
  logic       setup_phase;       // First cycle of a transfer
  logic       access_phase;      // Completing cycle of a transfer
  logic       wr_access;         // Write taking effect this edge
  logic       rd_access;         // Read completing this edge

  // Event vectors before and after routing to a rate path
  event_vec_t evt_set;           // Sticky events raised this cycle
  event_vec_t evt_live;          // Live service request levels
  event_vec_t mr_set;            // Events for the medium-rate path
  event_vec_t fr_set;            // Events for the fast-rate path
  event_vec_t mr_live;           // Live levels for the medium-rate path
  event_vec_t fr_live;           // Live levels for the fast-rate path

  // Bank outputs
  event_vec_t mr_status;         // Medium-rate status view
  event_vec_t mr_mask;           // Medium-rate mask
  event_vec_t mr_pending;        // Medium-rate masked events
  event_vec_t fr_status;         // Fast-rate status view
  event_vec_t fr_mask;           // Fast-rate mask
  event_vec_t fr_pending;        // Fast-rate masked events
  logic       mr_irq;            // Any medium-rate pending bit
  logic       fr_irq;            // Any fast-rate pending bit
  logic       done_already;      // Frame done still set in the active path

  // Frame information and test register state
  logic [`INFO_FLAGS_W+`INFO_COUNT_W-1:0] frame_info;  // Flags and count of last frame
  logic [`TEST_W-1:0]                     test_live;   // Synchronised serial signals
  logic [31:0]                            next_prdata; // Read data for the addressed register
  logic [31:0]                            prdata;      // Registered read data

  assign bus_sel      = decode_addr(i_paddr);
  assign setup_phase  = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  assign wr_access    = access_phase & i_pwrite;
  assign rd_access    = access_phase & ~i_pwrite;

  // Zero-wait slave: every access completes in its first access cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = access_phase & (bus_sel == sel_none);

  // Frame done of the path that is receiving decides whether info is lost
  assign done_already = i_fast_rate_sel ? fr_status[`BIT_RX_FRAME_DONE]
                                        : mr_status[`BIT_RX_FRAME_DONE];

  // Raise events from the datapath strobes
  always_comb begin
    evt_set = `STATUS_RST;
    // Overrun with an old end marker in the newest entry drops the whole frame
    evt_set[`BIT_RX_FRAME_LOST] = i_rx_overrun & i_rx_tail_has_eof; // RULE1 RULE2
    evt_set[`BIT_RX_INFO_LOST]  = i_rx_last_word_read & done_already; // RULE3
    evt_set[`BIT_RX_FRAME_DONE] = i_rx_last_word_read; // RULE4
    // An abort is only counted when underrun abort is enabled
    evt_set[`BIT_TX_ABORTED]    = i_tx_frame_aborted & i_tx_underrun_abort_ctl; // RULE8
    evt_set[`BIT_TX_FRAME_DONE] = i_tx_frame_sent | i_tx_frame_aborted; // RULE9
  end

  // Live service request levels; they follow the buffers with no stored state
  always_comb begin
    evt_live = `STATUS_RST;
    evt_live[`BIT_RX_SERVICE] = ~i_rx_fifo_empty & i_rx_enable & ~i_rx_discarding; // RULE6 RULE7
    evt_live[`BIT_TX_SERVICE] = ~i_tx_fifo_full & i_tx_enable; // RULE10
  end

  // Route events to the path that is active; the idle path sees nothing
  always_comb begin
    if (i_fast_rate_sel) begin
      mr_set  = `STATUS_RST;
      mr_live = `STATUS_RST;
      fr_set  = evt_set; // RULE14
      fr_live = evt_live;
    end else begin
      mr_set  = evt_set;
      mr_live = evt_live;
      fr_set  = `STATUS_RST;
      fr_live = `STATUS_RST;
    end
  end

  // Medium-rate status, mask and pending registers
  ir_event_bank u_mr_bank (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_set       (mr_set),
    .i_live      (mr_live),
    .i_status_wr (wr_access && (bus_sel == sel_mr_status)),
    .i_mask_wr   (wr_access && (bus_sel == sel_mr_mask)),
    .i_wdata     (i_pwdata[`EVENT_W-1:0]),
    .i_info_read (rd_access && (bus_sel == sel_frame_info)),
    .o_status    (mr_status),
    .o_mask      (mr_mask),
    .o_pending   (mr_pending),
    .o_irq       (mr_irq)
  );

  // Fast-rate status, mask and pending registers
  ir_event_bank u_fr_bank (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_set       (fr_set),
    .i_live      (fr_live),
    .i_status_wr (wr_access && (bus_sel == sel_fr_status)),
    .i_mask_wr   (wr_access && (bus_sel == sel_fr_mask)),
    .i_wdata     (i_pwdata[`EVENT_W-1:0]),
    .i_info_read (rd_access && (bus_sel == sel_frame_info)),
    .o_status    (fr_status),
    .o_mask      (fr_mask),
    .o_pending   (fr_pending),
    .o_irq       (fr_irq)
  );

  // Interrupt lines follow the pending registers directly
  assign o_port_irq = mr_irq; // RULE13
  assign o_fast_irq = fr_irq; // RULE14

  // Capture flags and count when the last word of a frame leaves the FIFO
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_info <= `INFO_RST;
    end else if (i_rx_last_word_read) begin
      // Counts past 2047 wrap; only the low eleven bits are kept
      frame_info <= {i_rx_byte_count[`INFO_COUNT_W-1:0], // RULE17
                     i_rx_framing_err, i_rx_overrun_flag,
                     i_rx_crc_err, i_rx_abort}; // RULE4
    end
  end

  // Serial signals may come from other clocks, so all four are synchronised
  ir_sync_bits u_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_slow_ir_enable, i_slow_ir_serial_out,
                 i_uart_tx_serial_in, i_uart_rx_serial_out}), // RULE15
    .o_sync    (test_live)
  );

  // Read multiplexer; reserved bits read as zero
  always_comb begin
    next_prdata = `READ_ZERO;
    case (bus_sel)
      sel_frame_info: begin
        next_prdata[`INFO_FLAGS_W+`INFO_COUNT_W-1:0] = frame_info;
      end
      sel_slow_test: begin
        next_prdata[`TEST_LSB+`TEST_W-1:`TEST_LSB] = test_live; // RULE15
      end
      sel_mr_status: begin
        next_prdata[`EVENT_W-1:0] = mr_status;
      end
      sel_mr_mask: begin
        next_prdata[`EVENT_W-1:0] = mr_mask;
      end
      sel_mr_pending: begin
        next_prdata[`EVENT_W-1:0] = mr_pending; // RULE12
      end
      sel_fr_status: begin
        next_prdata[`EVENT_W-1:0] = fr_status;
      end
      sel_fr_mask: begin
        next_prdata[`EVENT_W-1:0] = fr_mask;
      end
      sel_fr_pending: begin
        next_prdata[`EVENT_W-1:0] = fr_pending;
      end
      default: begin
        next_prdata = `READ_ZERO;
      end
    endcase
  end

  // Read data is sampled in the setup cycle and held through the access cycle;
  // the clear-on-read of frame done acts at the access edge, after the sample
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prdata <= `READ_ZERO;
    end else if (setup_phase && !i_pwrite) begin
      prdata <= next_prdata;
    end
  end

  assign o_prdata = prdata;

endmodule : ir_port_events

// *** sim/ir_port_events_monitor.sv ***
// Assertion checker watching the ports of the infrared event block
`include "ir_event_defines.svh"
module ir_port_events_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_fast_rate_sel,
  input wire logic        i_rx_overrun,
  input wire logic        i_rx_last_word_read,
  input wire logic        i_rx_fifo_empty,
  input wire logic        i_rx_discarding,
  input wire logic        i_rx_enable,
  input wire logic        i_tx_frame_sent,
  input wire logic        i_tx_frame_aborted,
  input wire logic        i_tx_fifo_full,
  input wire logic        i_tx_enable,
  input wire logic        o_port_irq,
  input wire logic        o_fast_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped; // Address hits a register
  logic rd_acc; // Read access cycle
  logic rd_set; // Read setup cycle
  logic quiet;  // No event and no bus write this cycle
  logic lv_off; // Both live service bits forced low
  assign mapped = i_paddr inside {`OFS_FRAME_INFO, `OFS_SLOW_IR_TEST, `OFS_MR_STATUS,
    `OFS_MR_INT_MASK, `OFS_MR_INT_PENDING, `OFS_FR_STATUS, `OFS_FR_INT_MASK,
    `OFS_FR_INT_PENDING};
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  assign rd_set = i_psel && !i_penable && !i_pwrite;
  assign quiet = !(i_rx_overrun || i_rx_last_word_read || i_tx_frame_sent
    || i_tx_frame_aborted || (i_psel && i_pwrite));
  assign lv_off = !i_rx_enable && !i_tx_enable;
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  ready_high_a: assert property (o_pready)
    else $error("ready low");
  slverr_map_a: assert property (o_pslverr == (i_psel && i_penable && !mapped))
    else $error("error flag wrong");
  unmapped_zero_a: assert property (rd_acc && !mapped |-> o_prdata == `READ_ZERO)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (rd_acc && i_paddr[7] |-> o_prdata[31:7] == 25'h0)
    else $error("reserved bits set");
  quiet_port_a: assert property (quiet && !o_port_irq ##1 lv_off |-> !o_port_irq)
    else $error("port irq without cause");
  quiet_fast_a: assert property (quiet && !o_fast_irq ##1 lv_off |-> !o_fast_irq)
    else $error("fast irq without cause");
  sticky_hold_a: assert property (o_port_irq && !i_psel && lv_off ##1 lv_off |-> o_port_irq)
    else $error("irq dropped alone");
  tx_live_a: assert property (rd_set && i_paddr == `OFS_MR_STATUS && !i_fast_rate_sel
    && i_tx_enable && !i_tx_fifo_full |=> o_prdata[`BIT_TX_SERVICE])
    else $error("tx service low");
  // The two status words carry the live receive service bit unmasked, pending words only under mask; mask words may hold a one
  rx_idle_a: assert property (rd_set && (i_paddr == `OFS_MR_STATUS || i_paddr == `OFS_FR_STATUS)
    && !(i_rx_enable && !i_rx_fifo_empty && !i_rx_discarding)
    |=> !o_prdata[`BIT_RX_SERVICE])
    else $error("rx service high");
  cover property (rd_acc && !mapped);
  cover property ($rose(o_port_irq));
  cover property ($rose(o_fast_irq));
endmodule : ir_port_events_monitor

// *** sim/ir_apb_host.sv ***
// APB host model standing for the processor and DMA side
module ir_apb_host (
  input  wire logic        i_sys_clk,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [31:0] o_paddr,
  output logic      [31:0] o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle from time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 32'h0000_0000;
    o_pwdata = 32'h0000_0000;
  end
  // One transfer; request held until ready is seen, slave speed not assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_sys_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (!i_pready) @(posedge i_sys_clk);
    q = i_prdata;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : ir_apb_host

// *** sim/ir_port_events_tb_top.sv ***
// Self-checking bench for the infrared port event block
`include "ir_event_defines.svh"
module ir_port_events_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b1;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_port_irq, o_fast_irq;
  logic [31:0] i_paddr, i_pwdata, o_prdata;
  logic [3:0] ev = 4'h0, flags = 4'h0, sir = 4'h0; // Event pulses, frame flags, serial lines
  logic [15:0] cnt = 16'h0000;
  logic i_fast_rate_sel = 0, tail = 0, rx_empty = 1, rx_disc = 0, rx_en = 0;
  logic tx_ctl = 0, tx_full = 0, tx_en = 0;
  wire logic i_rx_overrun, i_rx_last_word_read, i_tx_frame_sent, i_tx_frame_aborted;
  int num_errors = 0, cmp_count = 0, tick = 0;
  logic [31:0] regs [9] = '{`OFS_FRAME_INFO, `OFS_SLOW_IR_TEST, `OFS_MR_STATUS,
    `OFS_MR_INT_MASK, `OFS_MR_INT_PENDING, `OFS_FR_STATUS, `OFS_FR_INT_MASK,
    `OFS_FR_INT_PENDING, 32'h808b_0040};
  assign {i_tx_frame_aborted, i_tx_frame_sent, i_rx_last_word_read, i_rx_overrun} = ev;
  ir_port_events uut (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_fast_rate_sel, .i_rx_overrun,
    .i_rx_tail_has_eof(tail), .i_rx_last_word_read, .i_rx_fifo_empty(rx_empty),
    .i_rx_discarding(rx_disc), .i_rx_enable(rx_en), .i_rx_framing_err(flags[3]),
    .i_rx_overrun_flag(flags[2]), .i_rx_crc_err(flags[1]), .i_rx_abort(flags[0]),
    .i_rx_byte_count(cnt), .i_tx_frame_sent, .i_tx_frame_aborted,
    .i_tx_underrun_abort_ctl(tx_ctl), .i_tx_fifo_full(tx_full), .i_tx_enable(tx_en),
    .i_slow_ir_enable(sir[3]), .i_slow_ir_serial_out(sir[2]),
    .i_uart_tx_serial_in(sir[1]), .i_uart_rx_serial_out(sir[0]), .o_port_irq, .o_fast_irq);
  ir_apb_host host (.i_sys_clk, .o_psel(i_psel), .o_penable(i_penable),
    .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata), .i_prdata(o_prdata),
    .i_pready(o_pready));
  // 50 MHz clock
  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Hang guard; the whole run needs well under this many cycles
  always @(posedge i_sys_clk) begin
    tick++;
    if (tick == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk($sformatf("reg %h", a), q, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : wr
  // One-cycle event pulse
  task automatic pulse(input logic [3:0] v);
    @(posedge i_sys_clk);
    ev <= v;
    @(posedge i_sys_clk);
    ev <= 4'h0;
  endtask : pulse
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      sir <= i ? 4'h6 : 4'h9;
      repeat (3) @(posedge i_sys_clk);
      rd(`OFS_SLOW_IR_TEST, i ? 32'h0000_0060 : 32'h0000_0090);
    end
    wr(`OFS_MR_INT_MASK, 32'hffff_ffff);
    rd(`OFS_MR_INT_MASK, 32'h0000_007f);
    wr(`OFS_MR_INT_MASK, 32'h0000_0000);
    $display("Test registers done");
    // Count above 2047 keeps its low eleven bits
    flags <= 4'ha;
    cnt <= 16'h0a05;
    pulse(4'h2);
    rd(`OFS_MR_STATUS, 32'h0000_0010);
    pulse(4'h2);
    rd(`OFS_MR_STATUS, 32'h0000_0030);
    rd(`OFS_FRAME_INFO, 32'h0000_205a);
    rd(`OFS_MR_STATUS, 32'h0000_0020);
    wr(`OFS_MR_STATUS, 32'h0000_0000);
    rd(`OFS_MR_STATUS, 32'h0000_0020);
    wr(`OFS_MR_STATUS, 32'h0000_0020);
    pulse(4'h1);
    rd(`OFS_MR_STATUS, 32'h0000_0000);
    tail <= 1'b1;
    pulse(4'h1);
    rd(`OFS_MR_STATUS, 32'h0000_0040);
    wr(`OFS_MR_STATUS, 32'h0000_0040);
    $display("Receive events done");
    pulse(4'h8);
    rd(`OFS_MR_STATUS, 32'h0000_0002);
    tx_ctl <= 1'b1;
    pulse(4'h8);
    rd(`OFS_MR_STATUS, 32'h0000_0006);
    wr(`OFS_MR_STATUS, 32'h0000_0006);
    pulse(4'h4);
    rd(`OFS_MR_STATUS, 32'h0000_0002);
    // Clear and new event land on the same edge
    fork
      wr(`OFS_MR_STATUS, 32'h0000_0002);
      begin
        @(posedge i_sys_clk);
        pulse(4'h4);
      end
    join
    rd(`OFS_MR_STATUS, 32'h0000_0002);
    wr(`OFS_MR_INT_MASK, 32'h0000_0002);
    rd(`OFS_MR_INT_PENDING, 32'h0000_0002);
    repeat (2) @(posedge i_sys_clk);
    chk("port irq", {31'h0, o_port_irq}, 32'h1);
    wr(`OFS_MR_INT_MASK, 32'h0000_0000);
    rd(`OFS_MR_INT_PENDING, 32'h0000_0000);
    chk("port irq", {31'h0, o_port_irq}, 32'h0);
    wr(`OFS_MR_STATUS, 32'h0000_0002);
    $display("Transmit events done");
    tx_en <= 1'b1;
    rd(`OFS_MR_STATUS, 32'h0000_0001);
    tx_full <= 1'b1;
    rd(`OFS_MR_STATUS, 32'h0000_0000);
    rx_en <= 1'b1;
    rx_empty <= 1'b0;
    rd(`OFS_MR_STATUS, 32'h0000_0008);
    rx_disc <= 1'b1;
    rd(`OFS_MR_STATUS, 32'h0000_0000);
    rx_disc <= 1'b0;
    rx_empty <= 1'b1;
    rd(`OFS_MR_STATUS, 32'h0000_0000);
    $display("Service bits done");
    i_fast_rate_sel <= 1'b1;
    pulse(4'h4);
    rd(`OFS_FR_STATUS, 32'h0000_0002);
    rd(`OFS_MR_STATUS, 32'h0000_0000);
    wr(`OFS_FR_INT_MASK, 32'h0000_0002);
    repeat (2) @(posedge i_sys_clk);
    chk("fast irq", {31'h0, o_fast_irq}, 32'h1);
    $display("Fast path done");
    end_of_test();
  end
endmodule : ir_port_events_tb_top
bind ir_port_events ir_port_events_monitor mon (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_fast_rate_sel, .i_rx_overrun,
  .i_rx_last_word_read, .i_rx_fifo_empty, .i_rx_discarding, .i_rx_enable, .i_tx_frame_sent,
  .i_tx_frame_aborted, .i_tx_fifo_full, .i_tx_enable, .o_port_irq, .o_fast_irq);
